// ===== design/eef_defines.svh
// Purpose: Constants of the two-wire EEPROM bus front end
// Assumes: 25 MHz system clock
// Notes: Offsets are absent; only field values and timing counts live here
`ifndef EEF_DEFINES_SVH
`define EEF_DEFINES_SVH

// Device type identifier expected in bits 7..4 of the address byte
`define EEF_TYPE_ID 4'ha
// Field position of the read/write select bit in the address byte
`define EEF_RW_BIT 0
// Index of the last bit of a byte and the clock that carries the acknowledge
`define EEF_LAST_BIT 4'd7
`define EEF_ACK_SLOT 4'd8
// Clock rate in kHz and the host power-up wait in microseconds
`define EEF_MCLK_KHZ 25000
`define EEF_PUP_WAIT_US 100
// Host power-up wait in clock cycles, rounded up
`define EEF_PUP_WAIT_CYC ((`EEF_PUP_WAIT_US * `EEF_MCLK_KHZ + 999) / 1000)

`endif

// ===== design/eef_front.sv
// Purpose: Bit-level target front end of a two-wire serial EEPROM
// Assumes: rstn is the power-on reset; scl_i and sda_i come from pins
// Notes: SDA is open drain, driven low only; SCL is never driven
//
// How it works
// - Ignore bus during reset, standby after release
// - Sample on SCL rise, drive after fall
// - Bytes travel most significant bit first
// - Ninth clock carries acknowledge or no-acknowledge
// - SDA change with SCL high is start/stop
// - SDA fall, SCL high: start, wakes device
// - Silent until a start is seen
// - SDA rise, SCL high: stop, then standby unless the stop launches a write
// - Repeated start begins a new operation
// - Idle means both lines high
// - Sender releases at eighth fall; low acknowledges
// - Receiver releases at end of ninth clock
// - Host no-acknowledge: release SDA, then standby
// - Standby on power-up, stop that launches no write, write end, mismatch, no-acknowledge
// - SDA driven low only, open drain
// - SCL is input only
// - Acknowledge matching type identifier, else standby
// - No address acknowledge during write cycle
`timescale 1ns/1ps
`include "eef_defines.svh"
module eef_front (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rstn, // Power-on reset, active low
    input wire logic scl_i, // Serial clock pin, input only
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data output value, always low
    output logic sda_oe, // Serial data pull-down enable
    input wire logic wr_pend_i, // A stop now would launch a write cycle
    input wire logic write_busy_i, // Internal write cycle in progress
    input wire logic [7:0] tx_byte_i, // Next byte to send
    output logic tx_req, // Byte taken from tx_byte_i
    output logic [7:0] rx_byte, // Last byte received
    output logic rx_valid, // rx_byte complete
    output logic rx_addr, // rx_byte is the address byte
    output logic sel, // Device addressed in this operation
    output logic reading, // Addressed for read
    output logic standby, // Standby mode
    output logic bus_idle, // Both lines high
    output eef_pkg::eef_state_t state // Protocol state
);
    import eef_pkg::*;

    eef_line_if ln ();

    eef_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic oe_q, oe_d;
    logic first_q, first_d;
    logic rw_q, rw_d;
    logic nack_q, nack_d;
    logic sel_q, sel_d;
    logic rxv_q, rxv_d;
    logic rxa_q, rxa_d;
    logic txr_q, txr_d;
    logic stby_q, stby_d;
    logic por_q, wbusy_q;
    logic sh_load, sh_shift, sh_bit, type_ok;
    logic [7:0] sh_q;

    // Pin synchroniser and event finder
    eef_sync u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .ln (ln)
    );

    // Byte shifter for both directions
    eef_shreg u_shreg (
        .mclk (mclk),
        .rstn (rstn),
        .load (sh_load),
        .load_val (tx_byte_i),
        .shift (sh_shift),
        .bit_in (sh_bit),
        .q (sh_q)
    );

    assign type_ok = (sh_q[7:4] == `EEF_TYPE_ID);

    // Protocol next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        oe_d = oe_q;
        first_d = first_q;
        rw_d = rw_q;
        nack_d = nack_q;
        sel_d = sel_q;
        rxv_d = 1'b0;
        rxa_d = rxa_q;
        txr_d = 1'b0;
        stby_d = stby_q;
        sh_load = 1'b0;
        sh_shift = 1'b0;
        sh_bit = 1'b1;
        if (!por_q) begin
            stby_d = 1'b1;
        end
        if (wbusy_q && !write_busy_i) begin
            stby_d = 1'b1;
        end
        if (ln.start) begin
            // Start or repeated start aborts any byte and opens a new operation
            state_d = EEF_ST_RX;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            first_d = 1'b1;
            sel_d = 1'b0;
            stby_d = 1'b0;
        end else if (ln.stop) begin
            state_d = EEF_ST_STBY;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            sel_d = 1'b0;
            if (!wr_pend_i) begin
                stby_d = 1'b1;
            end
        end else begin
            unique case (state_q)
                EEF_ST_STBY: begin
                    oe_d = 1'b0;
                end
                EEF_ST_RX: begin
                    if (ln.scl_rise && cnt_q != `EEF_ACK_SLOT) begin
                        sh_shift = 1'b1;
                        sh_bit = ln.sda;
                        cnt_d = 4'(cnt_q + 4'h1);
                        if (cnt_q == `EEF_LAST_BIT) begin
                            rxv_d = 1'b1;
                            rxa_d = first_q;
                        end
                    end else if (ln.scl_fall && cnt_q == `EEF_ACK_SLOT) begin
                        if (first_q && !type_ok) begin
                            state_d = EEF_ST_STBY;
                            stby_d = 1'b1;
                        end else if (first_q && write_busy_i) begin
                            state_d = EEF_ST_STBY;
                        end else begin
                            oe_d = 1'b1;
                            state_d = EEF_ST_RXACK;
                            if (first_q) begin
                                rw_d = sh_q[`EEF_RW_BIT];
                                sel_d = 1'b1;
                            end
                        end
                    end
                end
                EEF_ST_RXACK: begin
                    if (ln.scl_fall) begin
                        cnt_d = 4'h0;
                        first_d = 1'b0;
                        if (rw_q) begin
                            state_d = EEF_ST_TX;
                            sh_load = 1'b1;
                            txr_d = 1'b1;
                            oe_d = ~tx_byte_i[7];
                        end else begin
                            state_d = EEF_ST_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                EEF_ST_TX: begin
                    if (ln.scl_fall) begin
                        cnt_d = 4'(cnt_q + 4'h1);
                        if (cnt_q == `EEF_LAST_BIT) begin
                            oe_d = 1'b0;
                            state_d = EEF_ST_TXACK;
                        end else begin
                            sh_shift = 1'b1;
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                EEF_ST_TXACK: begin
                    if (ln.scl_rise) begin
                        nack_d = ln.sda;
                    end else if (ln.scl_fall) begin
                        cnt_d = 4'h0;
                        if (nack_q) begin
                            state_d = EEF_ST_STBY;
                            stby_d = 1'b1;
                            sel_d = 1'b0;
                        end else begin
                            // Reads run on with no byte limit of their own
                            state_d = EEF_ST_TX;
                            sh_load = 1'b1;
                            txr_d = 1'b1;
                            oe_d = ~tx_byte_i[7];
                        end
                    end
                end
                default: begin
                    state_d = EEF_ST_STBY;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Protocol registers; reset holds the device off the bus
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= EEF_ST_STBY;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            nack_q <= 1'b1;
            sel_q <= 1'b0;
            rxv_q <= 1'b0;
            rxa_q <= 1'b0;
            txr_q <= 1'b0;
            stby_q <= 1'b0;
            por_q <= 1'b0;
            wbusy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            oe_q <= oe_d;
            first_q <= first_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
            sel_q <= sel_d;
            rxv_q <= rxv_d;
            rxa_q <= rxa_d;
            txr_q <= txr_d;
            stby_q <= stby_d;
            por_q <= 1'b1;
            wbusy_q <= write_busy_i;
        end
    end

    // Outputs; SDA only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign tx_req = txr_q;
    assign rx_byte = sh_q;
    assign rx_valid = rxv_q;
    assign rx_addr = rxa_q;
    assign sel = sel_q;
    assign reading = rw_q & sel_q;
    assign standby = stby_q;
    assign bus_idle = ln.idle;
    assign state = state_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Steps of a byte and its acknowledge
    sequence s_eighth_rx_bit;
        state_q == EEF_ST_RX && cnt_q == `EEF_LAST_BIT && ln.scl_rise && !ln.start && !ln.stop;
    endsequence
    sequence s_addr_slot;
        state_q == EEF_ST_RX && cnt_q == `EEF_ACK_SLOT && first_q && ln.scl_fall
            && !ln.start && !ln.stop;
    endsequence
    sequence s_eighth_tx_fall;
        state_q == EEF_ST_TX && cnt_q == `EEF_LAST_BIT && ln.scl_fall && !ln.start && !ln.stop;
    endsequence

    property p_silent_stby;
        state_q == EEF_ST_STBY |-> !oe_q;
    endproperty
    a_silent_stby: assert property (p_silent_stby)
        else $error("SDA driven while in standby");

    property p_drive_on_fall;
        $changed(oe_q) |-> $past(ln.scl_fall) || $past(ln.start) || $past(ln.stop);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall)
        else $error("SDA drive changed without an SCL fall");

    property p_start;
        ln.start |=> state_q == EEF_ST_RX && cnt_q == 4'h0 && first_q && !standby;
    endproperty
    a_start: assert property (p_start)
        else $error("Start did not open a new operation");

    property p_stop;
        ln.stop |=> state_q == EEF_ST_STBY && !oe_q && (standby || $past(wr_pend_i));
    endproperty
    a_stop: assert property (p_stop)
        else $error("Stop did not return to standby");

    property p_rx_byte;
        s_eighth_rx_bit |=> rx_valid && cnt_q == `EEF_ACK_SLOT && rx_byte[0] == $past(ln.sda);
    endproperty
    a_rx_byte: assert property (p_rx_byte)
        else $error("Eighth bit did not complete the byte");

    property p_mismatch;
        s_addr_slot ##0 !type_ok |=> state_q == EEF_ST_STBY && standby && !oe_q;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("Mismatched address byte was acknowledged");

    property p_busy_nack;
        s_addr_slot ##0 write_busy_i |=> !oe_q && state_q == EEF_ST_STBY;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("Address acknowledged during write cycle");

    property p_tx_release;
        s_eighth_tx_fall |=> state_q == EEF_ST_TXACK && !oe_q;
    endproperty
    a_tx_release: assert property (p_tx_release)
        else $error("SDA not released at eighth fall");

    property p_nack_end;
        state_q == EEF_ST_TXACK && nack_q && ln.scl_fall && !ln.start && !ln.stop
            |=> (state_q == EEF_ST_STBY && standby && !oe_q) [*2];
    endproperty
    a_nack_end: assert property (p_nack_end)
        else $error("No-acknowledge did not release the bus");

    property p_ack_release;
        state_q == EEF_ST_RXACK && !rw_q && ln.scl_fall && !ln.start && !ln.stop
            |=> !oe_q && state_q == EEF_ST_RX && cnt_q == 4'h0;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("Acknowledge not released after ninth clock");
endmodule : eef_front

// ===== design/eef_line_if.sv
// Purpose: Carries sampled line levels and bus events between modules
// Assumes: All members are on the mclk domain
// Notes: Events are one-cycle pulses
`timescale 1ns/1ps
interface eef_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic idle;
    modport src (output scl, sda, scl_rise, scl_fall, start, stop, idle);
    modport dst (input scl, sda, scl_rise, scl_fall, start, stop, idle);
endinterface : eef_line_if

// ===== design/eef_pkg.sv
// Purpose: Types of the two-wire EEPROM bus front end
// Assumes: Nothing beyond the defines header
// Notes: Gray codes follow receive, acknowledge, send, acknowledge
package eef_pkg;
    typedef enum logic [2:0] {
        EEF_ST_STBY = 3'h0,
        EEF_ST_RX = 3'h1,
        EEF_ST_RXACK = 3'h3,
        EEF_ST_TX = 3'h2,
        EEF_ST_TXACK = 3'h6
    } eef_state_t;
endpackage : eef_pkg

// ===== design/eef_shreg.sv
// Purpose: Byte shift register, most significant bit first
// Assumes: Load wins over shift
// Notes: Shared by receive and send
`timescale 1ns/1ps
module eef_shreg (
    input wire logic mclk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic load, // Parallel load strobe
    input wire logic [7:0] load_val, // Value to load
    input wire logic shift, // Shift strobe
    input wire logic bit_in, // Bit entering at the bottom
    output logic [7:0] q // Register contents
);
    logic [7:0] q_d;

    // Next value: load, shift toward the top, or hold
    always_comb begin
        q_d = q;
        if (load) begin
            q_d = load_val;
        end else if (shift) begin
            q_d = {q[6:0], bit_in};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= 8'h00;
        end else begin
            q <= q_d;
        end
    end
endmodule : eef_shreg

// ===== design/eef_sync.sv
// Purpose: Synchronises the bus pins and finds edges, start and stop
// Assumes: Pins are asynchronous to mclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module eef_sync (
    input wire logic mclk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    eef_line_if.src ln // Sampled levels and events
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] scl_d;
    logic [2:0] sda_d;

    // Shift chains: two synchroniser stages and one history stage
    always_comb begin
        scl_d = {scl_q[1:0], scl_i};
        sda_d = {sda_q[1:0], sda_i};
    end

    // Idle bus level after reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // Events from the second and third stages only
    assign ln.scl = scl_q[1];
    assign ln.sda = sda_q[1];
    assign ln.scl_rise = scl_q[1] & ~scl_q[2];
    assign ln.scl_fall = ~scl_q[1] & scl_q[2];
    assign ln.start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign ln.stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    assign ln.idle = scl_q[1] & sda_q[1];
endmodule : eef_sync

// ===== testbench/eef_front_tb_top.sv
// Purpose: Self-checking bench of the two-wire EEPROM bus front end
// Assumes: Host model makes SCL; SDA has a pull-up resolved here
// Notes: Expected bytes wait in queues; monitors compare on strobes
`timescale 1ns/1ps
`include "eef_defines.svh"
module eef_front_tb_top;
    import eef_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic scl, host_oe, sda_o, sda_oe, tx_req, rx_valid, rx_addr, sel, reading;
    logic standby, bus_idle;
    logic wr_pend = 1'b0;
    logic wr_busy = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte;
    eef_state_t state;
    logic [8:0] rx_q[$];
    logic [8:0] rx_e;
    logic addr_next = 1'b0;
    logic [7:0] tx_q[$];
    int err_count = 0;
    int checked = 0;
    // Open drain: only a low is ever driven, else the pull-up wins
    wire logic sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;

    eef_front i_eef_front (
        .mclk(mclk), // System clock
        .rstn(rstn), // Power-on reset
        .scl_i(scl), // Host clock
        .sda_i(sda), // Resolved data
        .sda_o(sda_o), // Data value
        .sda_oe(sda_oe), // Pull-down enable
        .wr_pend_i(wr_pend), // Stop would launch a write
        .write_busy_i(wr_busy), // Write cycle running
        .tx_byte_i(tx_byte), // Byte to send
        .tx_req(tx_req), // Byte taken
        .rx_byte(rx_byte), // Byte received
        .rx_valid(rx_valid), // Byte complete
        .rx_addr(rx_addr), // Address byte flag
        .sel(sel), // Addressed
        .reading(reading), // Addressed for read
        .standby(standby), // Standby mode
        .bus_idle(bus_idle), // Both lines high
        .state(state) // Protocol state
    );
    eef_host_model i_eef_host_model (
        .scl(scl), // Host clock
        .sda_oe(host_oe), // Host pull-down
        .sda(sda) // Resolved data
    );

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_byte

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Waits whole cycles, then steps off the edge so host edges avoid it
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #7;
    endtask : cyc

    // Host writes a byte; the receive monitor will expect it
    task automatic wr(input logic [7:0] d, input logic exp_ack);
        logic ack;
        rx_q.push_back({addr_next, d});
        addr_next = 1'b0;
        i_eef_host_model.wr_byte(d, ack);
        cmp_bit(ack, exp_ack, "acknowledge");
    endtask : wr

    // Host reads a byte and compares it with the oldest loaded byte
    task automatic rd(input logic nack);
        logic [7:0] d;
        logic [7:0] e;
        i_eef_host_model.rd_byte(nack, d);
        e = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hxx;
        cmp_byte(d, e, "read byte");
    endtask : rd

    // Receive monitor takes the oldest note at each byte strobe
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            rx_e = (rx_q.size() > 0) ? rx_q.pop_front() : {1'hx, 8'hxx};
            cmp_byte(rx_byte, rx_e[7:0], "rx");
            cmp_bit(rx_addr, rx_e[8], "address byte flag");
        end
    end

    // A start seen on the pins marks the next received byte as the address
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            addr_next = 1'b1;
        end
    end

    // Send feeder notes each loaded byte and offers a fresh one
    always @(negedge mclk) begin
        if (tx_req === 1'b1) begin
            tx_q.push_back(tx_byte);
            @(posedge mclk) tx_byte <= 8'($urandom);
        end
    end

    // Watchdog cuts a hang short
    initial begin
        #1ms;
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        logic b;
        int n;
        void'($urandom(32'hd2e91049));
        repeat (3) @(posedge mclk);
        cmp_bit(standby, 1'b0, "standby in reset");
        cmp_bit(sda_oe, 1'b0, "sda in reset");
        rstn <= 1'b1;
        cyc(2);
        cmp_bit(standby, 1'b1, "standby after reset");
        cmp_bit(bus_idle, 1'b1, "idle bus");
        cyc(`EEF_PUP_WAIT_CYC); // Host power-up wait
        // Write with several bytes, then a stop that launches nothing
        i_eef_host_model.start_c();
        cmp_bit(standby, 1'b0, "wake on start");
        wr(8'ha0, 1'b0);
        cmp_bit(sel, 1'b1, "addressed on match");
        cmp_bit(sda_o, 1'b0, "open drain value");
        repeat (3) wr(8'($urandom), 1'b0);
        i_eef_host_model.stop_c();
        cyc(4);
        cmp_bit(standby, 1'b1, "standby after stop");
        cmp_bit(state == EEF_ST_STBY, 1'b1, "idle state after stop");
        // Wrong type identifier
        i_eef_host_model.start_c();
        wr(8'h5e, 1'b1);
        cyc(3);
        cmp_bit(standby, 1'b1, "standby on mismatch");
        cmp_bit(sel, 1'b0, "not addressed on mismatch");
        i_eef_host_model.stop_c();
        // Stop that launches a write, polling while the write runs
        @(posedge mclk) wr_pend <= 1'b1;
        cyc(1);
        i_eef_host_model.start_c();
        wr(8'ha0, 1'b0);
        wr(8'($urandom), 1'b0);
        i_eef_host_model.stop_c();
        @(posedge mclk) wr_busy <= 1'b1;
        wr_pend <= 1'b0;
        cyc(4);
        cmp_bit(standby, 1'b0, "no standby on write launch");
        i_eef_host_model.start_c();
        wr(8'ha0, 1'b1);
        cyc(3);
        cmp_bit(standby, 1'b0, "no standby on busy refusal");
        @(posedge mclk) wr_busy <= 1'b0;
        cyc(3);
        cmp_bit(standby, 1'b1, "standby at write end");
        i_eef_host_model.stop_c();
        // Read after a repeated start, ended by the host's no-acknowledge
        @(posedge mclk) tx_byte <= 8'($urandom);
        cyc(1);
        i_eef_host_model.start_c();
        wr(8'ha0, 1'b0);
        i_eef_host_model.start_c(); // Repeated start
        wr(8'ha1, 1'b0);
        cmp_bit(reading, 1'b1, "addressed for read");
        rd(1'b0);
        rd(1'b1);
        cyc(2);
        cmp_bit(sda, 1'b1, "line released after nack");
        cmp_bit(standby, 1'b1, "standby after nack");
        i_eef_host_model.stop_c();
        // Start in mid-byte aborts the byte and restarts the count
        i_eef_host_model.start_c();
        for (int i = 0; i < 5; i++) i_eef_host_model.clk_bit(1'($urandom), b);
        i_eef_host_model.start_c();
        wr(8'ha0, 1'b0);
        i_eef_host_model.stop_c();
        // Interrupted read recovered by dummy clocks
        @(posedge mclk) tx_byte <= 8'h00;
        cyc(1);
        i_eef_host_model.start_c();
        wr(8'ha1, 1'b0);
        i_eef_host_model.recover(n, b);
        cmp_bit(b, 1'b1, "line released by dummy clocks");
        cmp_bit(n == 9, 1'b1, "dummy clock count");
        tx_q.delete();
        i_eef_host_model.start_c();
        i_eef_host_model.stop_c();
        cyc(4);
        cmp_bit(standby, 1'b1, "standby after recovery");
        cmp_bit(bus_idle, 1'b1, "idle at end");
        cmp_bit(rx_q.size() == 0, 1'b1, "all bytes seen");
        finish_test();
    end
endmodule : eef_front_tb_top

// ===== testbench/eef_host_model.sv
// Purpose: Behavioural two-wire bus master that faces the front end
// Assumes: The bench resolves SDA from both enables with a pull-up
// Notes: SCL stands high outside frames; bit period 320 ns
`timescale 1ns/1ps
module eef_host_model (
    output logic scl, // Serial clock to the device
    output logic sda_oe, // Host pull-down enable on SDA
    input wire logic sda // Resolved data line
);
    // Bus starts idle with both lines released
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // One clock: data set in the low phase, sampled mid-high
    task automatic clk_bit(input logic b, output logic s);
        sda_oe <= ~b;
        #80 scl <= 1'b1;
        #80 s = sda;
        #80 scl <= 1'b0;
        #80;
    endtask : clk_bit

    // Start or repeated start: SDA falls while SCL is high
    task automatic start_c();
        if (scl === 1'b0) begin
            sda_oe <= 1'b0;
            #80 scl <= 1'b1;
            #160;
        end
        #160 sda_oe <= 1'b1;
        #160 scl <= 1'b0;
        #80;
    endtask : start_c

    // Stop: SDA rises while SCL is high, then SCL stays still
    task automatic stop_c();
        sda_oe <= 1'b1;
        #80 scl <= 1'b1;
        #160 sda_oe <= 1'b0;
        #160;
    endtask : stop_c

    // Byte out, top bit first, ninth clock samples the answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], ack);
        end
        clk_bit(1'b1, ack); // Line released at the eighth fall
    endtask : wr_byte

    // Byte in, then the host answer; released after the ninth clock
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(nack, s); // Low holds for the whole high phase
    endtask : rd_byte

    // Dummy clocks until SDA reads high, nine at most
    task automatic recover(output int n, output logic s);
        n = 0;
        do begin
            clk_bit(1'b1, s);
            n++;
        end while (s !== 1'b1 && n < 9);
    endtask : recover
endmodule : eef_host_model
